// [hw/rdm_params.svh]
/*
 shared constants for the dropped-frame / mac-register / flow-control block:
 register offsets, field positions, reset values and timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef RDM_PARAMS_SVH
`define RDM_PARAMS_SVH

// register byte offsets on the apb bus
`define RDM_OFF_DROP 8'hA0
`define RDM_OFF_CMD 8'hA4
`define RDM_OFF_DATA 8'hA8
`define RDM_OFF_FLOW 8'hAC
`define RDM_OFF_CTRL 8'hB4

// command register fields
`define RDM_CMD_BUSY 31
`define RDM_CMD_RNW 30
`define RDM_CMD_IDX_HI 7

// flow config fields
`define RDM_FLOW_HI_HI 23
`define RDM_FLOW_HI_LO 16
`define RDM_FLOW_LO_HI 15
`define RDM_FLOW_LO_LO 8
`define RDM_FLOW_DUR_HI 7
`define RDM_FLOW_DUR_LO 4
`define RDM_FLOW_WMASK 32'h00FFFFFF

// control register fields (tx enable, full duplex, 10 mbit)
`define RDM_CTRL_TXEN 0
`define RDM_CTRL_FDX 1
`define RDM_CTRL_SLOW 2
`define RDM_CTRL_WMASK 32'h00000007

// reset value and halfway point of the drop count
`define RDM_RST_ZERO 32'h00000000
`define RDM_HALF_POINT 32'h80000000

// fifo level unit in bytes, expressed as a shift
`define RDM_LEVEL_SHIFT 6

// timing: clock period and jam duration base figures
`define RDM_CLK_NS 4
`define RDM_JAM_EXTRA_NS 2200
`endif

// [hw/rdm_pkg.sv]
/*
 types for the dropped-frame / mac-register / flow-control block.
 assumes nothing beyond the shared constants header.
*/
package rdm_pkg;
    // mac register access sequencer
    typedef enum logic [1:0] {
        RDM_IDLE = 2'b00,
        RDM_REQ = 2'b01,
        RDM_DONE = 2'b10
    } rdm_acc_state_t;

    // automatic flow control state
    typedef enum logic [1:0] {
        RDM_FC_CLEAR = 2'b00,
        RDM_FC_PAUSED = 2'b01,
        RDM_FC_JAMMING = 2'b10
    } rdm_fc_state_t;
endpackage

// [hw/rdm_jam_timer.sv]
/*
 jam duration timer: loads a cycle count from the 4-bit duration code and
 link speed, then counts down while active.
 assumes start is a single-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rdm_params.svh"

module rdm_jam_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    input wire logic [3:0] dur_code,
    input wire logic slow_link,
    // status
    output logic active
);
    // duration in microseconds per code, at 100 mbit
    function automatic logic [31:0] rdm_dur_us(input logic [3:0] code);
        case (code)
            4'h0: rdm_dur_us = 32'd5;
            4'h1: rdm_dur_us = 32'd10;
            4'h2: rdm_dur_us = 32'd15;
            default: rdm_dur_us = (code == 4'h3) ? 32'd25 : (code == 4'h4) ? 32'd50 :
                (code == 4'h5) ? 32'd100 : 32'd50 * ({28'h0000000, code} - 32'd3);
        endcase
    endfunction

    logic [31:0] load_cycles;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    // 10 mbit adds a fixed slot-related extension
    assign load_cycles = (rdm_dur_us(dur_code) * 32'd1000) / `RDM_CLK_NS
        + (slow_link ? 32'(`RDM_JAM_EXTRA_NS / `RDM_CLK_NS) : 32'h00000000);
    assign cnt_d = start ? load_cycles : (cnt_q != 32'h00000000) ? cnt_q - 32'h00000001 : cnt_q;
    assign active = (cnt_q != 32'h00000000);

    // countdown register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h00000000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// [hw/rdm_csr_block.sv]
/*
 dropped-frame counter, indirect mac register access and automatic flow
 control, reached over apb.
 assumes the mac side answers mac_ack on the same clock; frame and fifo
 status arrive as pins and are synchronised here.
*/

// Contract
// R1: every dropped receive frame adds one to the 32-bit count.
// R2: any read returns the count then clears it; zero after reset.
// R3: an event fires when the count steps from 7FFFFFFF to 80000000.
// R4: writing busy bit starts the access; it reads one until done.
// R5: read data sits in the data register before busy clears.
// R6: host leaves command and data alone while busy is set.
// R7: bit 30 selects read (one) or write (zero); resets to zero.
// R8: bits 7:0 select the mac register; reserved bits read zero.
// R9: data register carries write value or receives read value.
// R10: with transmitter disabled, no pause frames and no back pressure.
// R11: bits 23:16 hold high threshold in 64-byte units; reaching it triggers.
// R12: on high threshold apply jam or pause per enable bits 3:0; full duplex pauses only with bit 0 set, bits 3:1 alone send no pause.
// R13: full duplex sends exactly one pause frame using the mac pause time.
// R14: half duplex jams every matching frame for the jam duration.
// R15: bits 15:8 low threshold; falling below sends a zero-time pause.
// R16: zero-time pause only after a high-threshold pause was sent.
// R17: software keeps low threshold strictly below high threshold.
// R18: bits 7:4 set jam duration; unused in full duplex.
// R19: any-frame bit 0 overrides multicast, broadcast, address bits 3:1.
// R20: a drop coincident with the clearing read survives as count one.
`timescale 1ns/1ps
`default_nettype none
`include "rdm_params.svh"

module rdm_csr_block (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive path status pins
    input wire logic frame_dropped,
    input wire logic [13:0] rx_fifo_bytes,
    input wire logic frame_start,
    input wire logic frame_multicast,
    input wire logic frame_broadcast,
    input wire logic frame_addr_match,
    // mac register port
    output logic mac_req,
    output logic mac_read_not_write,
    output logic [7:0] mac_index,
    output logic [31:0] mac_wdata,
    input wire logic mac_ack,
    input wire logic [31:0] mac_rdata,
    // flow control outputs
    output logic pause_send,
    output logic pause_zero_time,
    output logic jam_active,
    // events
    output logic drop_half_event
);
    // synchroniser stages, level filter and edge history for pin inputs
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [13:0] lvl_s1_q;
    logic [13:0] lvl_s2_q;
    logic [13:0] lvl_s3_q;
    logic [13:0] lvl_q;
    logic drop_prev_q;
    logic fstart_prev_q;

    // register state
    logic [31:0] drop_cnt_q;
    logic [31:0] drop_cnt_d;
    logic cmd_busy_q;
    logic cmd_rnw_q;
    logic [7:0] cmd_idx_q;
    logic [31:0] data_q;
    logic [23:0] flow_cfg_q;
    logic [2:0] ctrl_q;
    logic half_q;
    rdm_pkg::rdm_acc_state_t acc_q;
    rdm_pkg::rdm_acc_state_t acc_d;
    rdm_pkg::rdm_fc_state_t fc_q;
    rdm_pkg::rdm_fc_state_t fc_d;
    logic pause_q;
    logic pzero_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_word;

    // decoded strobes
    wire access = psel & penable;
    wire wr_en = access & pwrite;
    wire rd_en = access & ~pwrite;
    wire hit_drop = (paddr == `RDM_OFF_DROP);
    wire hit_cmd = (paddr == `RDM_OFF_CMD);
    wire hit_data = (paddr == `RDM_OFF_DATA);
    wire hit_flow = (paddr == `RDM_OFF_FLOW);
    wire hit_ctrl = (paddr == `RDM_OFF_CTRL);
    wire mapped = hit_drop | hit_cmd | hit_data | hit_flow | hit_ctrl;
    wire drop_pulse = pin_s2_q[0] & ~drop_prev_q;
    wire fstart_pulse = pin_s2_q[1] & ~fstart_prev_q;
    wire is_mcast = pin_s2_q[2];
    wire is_bcast = pin_s2_q[3];
    wire is_match = pin_s2_q[4];
    wire clr_read = rd_en & hit_drop;
    wire wr_cmd = wr_en & hit_cmd & ~cmd_busy_q; // R6
    wire wr_data = wr_en & hit_data & ~cmd_busy_q;
    wire mac_done = (acc_q == rdm_pkg::RDM_REQ) & mac_ack;

    // flow control decode
    wire [7:0] thr_hi = flow_cfg_q[`RDM_FLOW_HI_HI:`RDM_FLOW_HI_LO];
    wire [7:0] thr_lo = flow_cfg_q[`RDM_FLOW_LO_HI:`RDM_FLOW_LO_LO];
    wire [3:0] jam_code = flow_cfg_q[`RDM_FLOW_DUR_HI:`RDM_FLOW_DUR_LO];
    wire [7:0] level_units = lvl_q[13:`RDM_LEVEL_SHIFT];
    wire tx_en = ctrl_q[`RDM_CTRL_TXEN];
    wire full_dx = ctrl_q[`RDM_CTRL_FDX];
    wire slow_link = ctrl_q[`RDM_CTRL_SLOW];
    wire any_en = flow_cfg_q[0];
    wire fc_enabled = |flow_cfg_q[3:0];
    wire at_high = (level_units >= thr_hi); // R11
    wire below_low = (level_units < thr_lo);
    wire frame_match = any_en | (flow_cfg_q[3] & is_mcast) | (flow_cfg_q[2] & is_bcast)
        | (flow_cfg_q[1] & is_match); // R19
    wire jam_start = (fc_q == rdm_pkg::RDM_FC_JAMMING) & fstart_pulse & frame_match & tx_en; // R14
    wire jam_busy;

    // one step of the flow machine between two given states; both pause strobes use it
    function automatic logic fc_step(input rdm_pkg::rdm_fc_state_t cur_s, nxt_s, from_s, to_s);
        fc_step = (cur_s == from_s) && (nxt_s == to_s);
    endfunction
    wire pause_entry = fc_step(fc_q, fc_d, rdm_pkg::RDM_FC_CLEAR, rdm_pkg::RDM_FC_PAUSED);
    wire pause_release = fc_step(fc_q, fc_d, rdm_pkg::RDM_FC_PAUSED, rdm_pkg::RDM_FC_CLEAR);

    // drop counter: increment wins over the clearing read
    assign drop_cnt_d = clr_read ? {31'h00000000, drop_pulse} // R2 R20
        : drop_cnt_q + {31'h00000000, drop_pulse}; // R1

    // mac access sequencer
    always_comb begin
        acc_d = acc_q;
        case (acc_q)
            rdm_pkg::RDM_IDLE: begin
                if (cmd_busy_q) begin
                    acc_d = rdm_pkg::RDM_REQ;
                end
            end
            rdm_pkg::RDM_REQ: begin
                if (mac_ack) begin
                    acc_d = rdm_pkg::RDM_DONE;
                end
            end
            rdm_pkg::RDM_DONE: acc_d = rdm_pkg::RDM_IDLE;
            default: acc_d = rdm_pkg::RDM_IDLE;
        endcase
    end

    // flow control state machine
    always_comb begin
        fc_d = fc_q;
        case (fc_q)
            rdm_pkg::RDM_FC_CLEAR: begin
                // in full duplex only the any-frame bit arms a pause, so other bits cannot toggle the state
                if (tx_en && fc_enabled && at_high && (any_en || !full_dx)) begin // R10 R12
                    fc_d = full_dx ? rdm_pkg::RDM_FC_PAUSED : rdm_pkg::RDM_FC_JAMMING; // R13
                end
            end
            rdm_pkg::RDM_FC_PAUSED: begin
                if (below_low) begin
                    fc_d = rdm_pkg::RDM_FC_CLEAR; // R15 R16
                end
            end
            rdm_pkg::RDM_FC_JAMMING: begin
                if (!at_high || !fc_enabled || full_dx) begin
                    fc_d = rdm_pkg::RDM_FC_CLEAR;
                end
            end
            default: fc_d = rdm_pkg::RDM_FC_CLEAR;
        endcase
    end

    // pin synchronisers, two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            lvl_s1_q <= 14'h0000;
            lvl_s2_q <= 14'h0000;
        end else begin
            pin_s1_q <= {frame_addr_match, frame_broadcast, frame_multicast, frame_start, frame_dropped};
            pin_s2_q <= pin_s1_q;
            lvl_s1_q <= rx_fifo_bytes;
            lvl_s2_q <= lvl_s1_q;
        end
    end

    // edge detectors; reset low like the idle pins, so no false edge follows reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_prev_q <= 1'b0;
            fstart_prev_q <= 1'b0;
        end else begin
            drop_prev_q <= pin_s2_q[0];
            fstart_prev_q <= pin_s2_q[1];
        end
    end

    // the level word is synchronised bit by bit, so one sample may mix two values;
    // it is taken only when two successive samples agree, costing one cycle of latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_s3_q <= 14'h0000;
            lvl_q <= 14'h0000;
        end else begin
            lvl_s3_q <= lvl_s2_q;
            if (lvl_s2_q == lvl_s3_q) begin
                lvl_q <= lvl_s2_q;
            end
        end
    end

    // drop counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_cnt_q <= `RDM_RST_ZERO;
        end else begin
            drop_cnt_q <= drop_cnt_d;
        end
    end

    // halfway event: a one-cycle pulse as the count steps onto the halfway value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q <= 1'b0;
        end else begin
            half_q <= (drop_cnt_d == `RDM_HALF_POINT) && (drop_cnt_q != `RDM_HALF_POINT); // R3
        end
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= rdm_pkg::RDM_IDLE;
        end else begin
            acc_q <= acc_d;
        end
    end

    // command register; a write while busy is dropped so the running access keeps its target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_busy_q <= 1'b0;
            cmd_rnw_q <= 1'b0;
            cmd_idx_q <= 8'h00;
        end else if (wr_cmd) begin // R6
            cmd_busy_q <= pwdata[`RDM_CMD_BUSY]; // R4
            cmd_rnw_q <= pwdata[`RDM_CMD_RNW]; // R7
            cmd_idx_q <= pwdata[`RDM_CMD_IDX_HI:0]; // R8
        end else if (acc_q == rdm_pkg::RDM_DONE) begin
            cmd_busy_q <= 1'b0; // R4
        end
    end

    // data register; the mac answer wins, host writes while busy are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= `RDM_RST_ZERO;
        end else if (mac_done && cmd_rnw_q) begin
            data_q <= mac_rdata; // R5 R9
        end else if (wr_data) begin
            data_q <= pwdata; // R9
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_cfg_q <= 24'h000000;
            ctrl_q <= 3'h0;
        end else begin
            if (wr_en && hit_flow) begin
                flow_cfg_q <= pwdata[23:0];
            end
            if (wr_en && hit_ctrl) begin
                ctrl_q <= pwdata[2:0];
            end
        end
    end

    // flow state and pause strobes: one pause on entry, one zero-time pause on release, never with tx off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_q <= rdm_pkg::RDM_FC_CLEAR;
            pause_q <= 1'b0;
            pzero_q <= 1'b0;
        end else begin
            fc_q <= fc_d;
            pause_q <= tx_en && (pause_entry || pause_release); // R10 R13 R15
            pzero_q <= tx_en && pause_release; // R10 R16
        end
    end

    // read word; the drop register shows the next count, so a drop on the setup edge
    // is reported by this read instead of being lost to the clear on the access edge
    assign rd_word = hit_drop ? drop_cnt_d // R1 R2
        : hit_cmd ? {cmd_busy_q, cmd_rnw_q, 22'h000000, cmd_idx_q}
        : hit_data ? data_q
        : hit_flow ? {8'h00, flow_cfg_q}
        : hit_ctrl ? {29'h0000000, ctrl_q}
        : `RDM_RST_ZERO;

    // read data register, loaded in the setup phase so the access needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= `RDM_RST_ZERO;
        end else if (psel && !penable) begin
            rdata_q <= rd_word;
        end
    end

    // jam timer, half duplex only
    rdm_jam_timer u_jam (
        .pclk(pclk),
        .presetn(presetn),
        .start(jam_start & ~full_dx), // R18
        .dur_code(jam_code),
        .slow_link(slow_link),
        .active(jam_busy)
    );

    // outputs
    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign mac_req = (acc_q == rdm_pkg::RDM_REQ);
    assign mac_read_not_write = cmd_rnw_q;
    assign mac_index = cmd_idx_q;
    assign mac_wdata = data_q;
    assign pause_send = pause_q;
    assign pause_zero_time = pzero_q;
    assign jam_active = jam_busy & tx_en & ~full_dx; // R10 R14
    assign drop_half_event = half_q;
endmodule
`default_nettype wire

// [sim/rdm_mac_model.sv]
/*
 mac register file on the far side of the indirect access port.
 assumes the same clock as the block; answers each request after dly cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rdm_mac_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // mac register port
    input wire logic mac_req,
    input wire logic mac_read_not_write,
    input wire logic [7:0] mac_index,
    input wire logic [31:0] mac_wdata,
    output logic mac_ack,
    output logic [31:0] mac_rdata,
    // answer delay in cycles
    input wire logic [3:0] dly
);
    logic [31:0] mem [256];
    int n;
    // one ack per request; read data is scrambled outside the ack cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n = 0;
            mac_ack <= 1'b0;
            mac_rdata <= 32'h00000000;
        end else begin
            mac_ack <= 1'b0;
            mac_rdata <= ~mac_rdata;
            if (mac_req && !mac_ack) begin
                if (n >= dly) begin
                    n = 0;
                    mac_ack <= 1'b1;
                    if (mac_read_not_write) mac_rdata <= mem[mac_index];
                    else mem[mac_index] <= mac_wdata;
                end else n = n + 1;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/rdm_csr_block_checker.sv]
/*
 port-level assertions for the csr block.
 assumes binding to rdm_csr_block; one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rdm_csr_block_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    // mac port
    input wire logic mac_req,
    input wire logic mac_read_not_write,
    input wire logic [7:0] mac_index,
    input wire logic [31:0] mac_wdata,
    input wire logic mac_ack,
    // flow control and events
    input wire logic pause_send,
    input wire logic pause_zero_time,
    input wire logic jam_active,
    input wire logic drop_half_event
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic cmd_rd = psel && penable && !pwrite && paddr == 8'hA4;
    logic hi_sent_q;
    // a zero pause must follow a full pause, so remember the last kind sent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_sent_q <= 1'b0;
        else if (pause_send) hi_sent_q <= !pause_zero_time;
    end
    a_half_pulse: assert property (drop_half_event |=> !drop_half_event) else $error("halfway event too long");
    a_pause_pulse: assert property (pause_send |=> !pause_send) else $error("pause pulse too long");
    a_zero_pause: assert property (pause_zero_time |-> pause_send) else $error("zero time without pause");
    a_zero_after_hi: assert property (pause_zero_time |-> hi_sent_q) else $error("zero pause before pause");
    a_req_holds: assert property (mac_req && !mac_ack |=> mac_req && $stable(mac_index)
        && $stable(mac_read_not_write)) else $error("mac request changed");
    a_wdata_holds: assert property (mac_req && !mac_ack && !mac_read_not_write |=> $stable(mac_wdata))
        else $error("mac write data changed");
    a_req_ends: assert property (mac_ack |=> !mac_req) else $error("mac request after ack");
    a_busy_reads: assert property (cmd_rd && mac_req |-> prdata[31]) else $error("busy read as zero");
    a_cmd_reserved: assert property (cmd_rd |-> prdata[29:8] == 22'h000000) else $error("reserved bits set");
    c_zero_pause: cover property (pause_zero_time);
    c_mac_read: cover property (mac_ack && mac_read_not_write);
    c_jam: cover property ($rose(jam_active));
endmodule
bind rdm_csr_block rdm_csr_block_checker rdm_csr_block_checker_inst (.*);
`default_nettype wire

// [sim/rdm_csr_block_tb.sv]
/*
 self-checking bench for the csr block with a mac register model.
 assumes 250 mhz pclk and jam code 0 lasting 1250 cycles at 100 mbit.
*/
`timescale 1ns/1ps
`default_nettype none
module rdm_csr_block_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic frame_dropped = 1'b0, frame_start = 1'b0, frame_multicast = 1'b0, frame_broadcast = 1'b0;
    logic frame_addr_match = 1'b0, mac_req, mac_read_not_write, mac_ack;
    logic pause_send, pause_zero_time, jam_active, drop_half_event;
    logic [7:0] paddr = 8'h00, mac_index, idx;
    logic [3:0] dly = 4'h0;
    logic [13:0] rx_fifo_bytes = 14'h0000;
    logic [31:0] pwdata = 32'h00000000, prdata, mac_wdata, mac_rdata, rd, d, rnd = 32'h00013409;
    logic [7:0] regs [5] = '{8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB4};
    int failures = 0, comparisons = 0, pauses = 0, zeros = 0, jams = 0, cyc = 0, cnt = 0, halfs = 0;
    rdm_csr_block rdm_csr_block_inst (.*);
    rdm_mac_model rdm_mac_model_inst (.*);
    always #2 pclk = ~pclk;
    // tallies of flow control activity and halfway events plus the hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        pauses <= pauses + int'(pause_send);
        zeros <= zeros + int'(pause_zero_time);
        jams <= jams + int'(jam_active);
        halfs <= halfs + int'(drop_half_event);
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until the edge that samples pready high; the answer is taken at that edge only
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_idle();
        apb(1'b0, 8'hA4, 32'h00000000);
        chk("busy set", 32'h00000001, {31'h0, rd[31]});
        repeat (40) if (rd[31] !== 1'b0) apb(1'b0, 8'hA4, 32'h00000000);
    endtask
    task automatic frame(input logic [2:0] q);
        @(posedge pclk) {frame_multicast, frame_broadcast, frame_addr_match} <= q;
        @(posedge pclk) frame_start <= 1'b1;
        @(posedge pclk) frame_start <= 1'b0;
        repeat (1300) @(posedge pclk);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h00000000);
            chk("reset value", 32'h00000000, rd);
        end
        apb(1'b0, 8'h10, 32'h00000000);
        chk("unmapped error", 32'h00000001, {31'h0, err});
        apb(1'b1, 8'hAC, 32'hFFFFFFFF);
        apb(1'b0, 8'hAC, 32'h00000000);
        chk("flow readback", 32'h00FFFFFF, rd);
        $display("register test done");
        rnd = lfsr(rnd);
        repeat (rnd[2:0] + 1) begin
            @(posedge pclk) frame_dropped <= 1'b1;
            @(posedge pclk) frame_dropped <= 1'b0;
            cnt++;
        end
        repeat (4) @(posedge pclk);
        apb(1'b0, 8'hA0, 32'h00000000);
        chk("drop count", cnt, rd);
        frame_dropped <= 1'b1;
        fork
            @(posedge pclk) frame_dropped <= 1'b0;
            apb(1'b0, 8'hA0, 32'h00000000);
        join
        chk("count cleared", 32'h00000000, rd);
        apb(1'b0, 8'hA0, 32'h00000000);
        chk("drop kept", 32'h00000001, rd);
        chk("no halfway event", 32'h00000000, halfs);
        $display("drop test done");
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            {d, idx} = {rnd, rnd[15:8]};
            dly <= k ? rnd[3:0] : 4'h0;
            apb(1'b1, 8'hA8, d);
            apb(1'b1, 8'hA4, 32'h80FFFF00 | idx);
            wait_idle();
            chk("cmd readback", {24'h000000, idx}, rd);
            chk("mac write", d, rdm_mac_model_inst.mem[idx]);
            apb(1'b1, 8'hA8, ~d);
            apb(1'b1, 8'hA4, 32'hC0000000 | idx);
            wait_idle();
            chk("read cmd", 32'h40000000 | idx, rd);
            apb(1'b0, 8'hA8, 32'h00000000);
            chk("mac read", d, rd);
        end
        $display("mac test done");
        apb(1'b1, 8'hAC, 32'h00100801);
        apb(1'b1, 8'hB4, 32'h00000002);
        rx_fifo_bytes <= 14'd1024;
        repeat (20) @(posedge pclk);
        chk("pause tx off", 32'h00000000, pauses);
        rx_fifo_bytes <= 14'd1023;
        repeat (10) @(posedge pclk);
        apb(1'b1, 8'hB4, 32'h00000003);
        repeat (20) @(posedge pclk);
        chk("below high", 32'h00000000, pauses);
        rx_fifo_bytes <= 14'd1024;
        repeat (30) @(posedge pclk);
        chk("one pause", 32'h00000001, pauses);
        chk("pause time kept", 32'h00000000, zeros);
        rx_fifo_bytes <= 14'd448;
        repeat (20) @(posedge pclk);
        chk("zero pause", 32'h00000002, pauses);
        chk("zero time", 32'h00000001, zeros);
        chk("no jam duplex", 32'h00000000, jams);
        $display("pause test done");
        apb(1'b1, 8'hAC, 32'h00100802);
        apb(1'b1, 8'hB4, 32'h00000001);
        rx_fifo_bytes <= 14'd1024;
        frame(3'b100);
        chk("unmatched frame", 32'h00000000, jams);
        frame(3'b001);
        chk("jam length", 32'd1250, jams);
        apb(1'b1, 8'hAC, 32'h00100801);
        frame(3'b000);
        chk("any frame jam", 32'd2500, jams);
        $display("jam test done");
        close_out();
    end
endmodule
`default_nettype wire
